// File: include/swl_cfg.svh
// Timing constants for the single-line slot link, in microseconds and clock cycles
`ifndef SWL_CFG_SVH
`define SWL_CFG_SVH
`define SWL_CLK_MHZ 10
`define SWL_US_SLOT_MIN 60
`define SWL_US_SLOT_MAX 120
`define SWL_US_LOW1_MIN 1
`define SWL_US_LOW1_MAX 15
`define SWL_US_LOW0_MIN 60
`define SWL_US_LOWR_MIN 1
`define SWL_US_LOWR_MAX 15
`define SWL_US_RDV 15
`define SWL_US_REL_MAX 45
`define SWL_US_SU_MAX 1
`define SWL_US_REC_MIN 1
`define SWL_US_RSTH_MIN 480
`define SWL_US_RSTL_MIN 480
`define SWL_US_RSTL_MAX 960
`define SWL_US_PDH_MIN 15
`define SWL_US_PDH_MAX 60
`define SWL_US_PDL_MIN 60
`define SWL_US_PDL_MAX 240
`define SWL_US_SAMPLE 30
`define SWL_US_RST_DETECT 120
`define SWL_US_MSAMPLE 12
`define SWL_US_LOW1_USE 6
`define SWL_US_LOWR_USE 3
`define SWL_US_LOW0_USE 70
`define SWL_US_SLOT_USE 90
`define SWL_US_REC_USE 5
`define SWL_US_RSTL_USE 600
`define SWL_US_RSTH_USE 600
`define SWL_US_PDH_USE 30
`define SWL_US_PDL_USE 120
// Cycle counts
`define SWL_CYC(us) ((us) * `SWL_CLK_MHZ)
`define SWL_CW 16
`endif

// File: include/swl_pkg.sv
// Types used by the master end of the single-line slot link and by the bench
package swl_pkg;
  typedef enum logic [2:0] {
    SWL_OP_RESET = 3'h1,
    SWL_OP_WRITE = 3'h2,
    SWL_OP_READ = 3'h4
  } swl_op_t;
endpackage

// File: include/swl_if.sv
// Shared open-drain line with one modport for each end
`timescale 1ns/1ns
interface swl_if;
  logic mst_oe;
  logic slv_oe;
  logic line_in;
  // Wired-AND with a pull-up: any enabled driver pulls the line low
  assign line_in = ~(mst_oe | slv_oe);
  modport master (output mst_oe, input line_in);
  modport slave (output slv_oe, input line_in);
endinterface

// File: rtl/swl_slave.sv
// Slave end: slot timing from the master's falling edge
`timescale 1ns/1ns
`include "swl_cfg.svh"
module swl_slave #(
  parameter int CW = `SWL_CW,
  // Slot timing in clock cycles; sample, hold and reset detect count from the falling edge, presence wait from the reset low's end, pulse from its start
  parameter int SAMPLE_CYC = `SWL_CYC(`SWL_US_SAMPLE),
  parameter int HOLD0_CYC = `SWL_CYC(`SWL_US_RDV + `SWL_US_REL_MAX / 3),
  parameter int RSTDET_CYC = `SWL_CYC(`SWL_US_RST_DETECT),
  parameter int PDH_CYC = `SWL_CYC(`SWL_US_PDH_USE),
  parameter int PDL_CYC = `SWL_CYC(`SWL_US_PDL_USE)
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Shared line
  swl_if.slave bus,
  // User side: bit to send in read slots
  input wire logic i_tx_bit,
  // User side: received bits and events
  output logic o_rx_valid,
  output logic o_rx_bit,
  output logic o_tx_taken,
  output logic o_reset_seen
);
  // Counts cut to the counter width on purpose
  localparam logic [CW-1:0] SAMPLE_C = CW'(SAMPLE_CYC);
  localparam logic [CW-1:0] HOLD0_C = CW'(HOLD0_CYC);
  localparam logic [CW-1:0] RSTDET_C = CW'(RSTDET_CYC);
  localparam logic [CW-1:0] PDH_C = CW'(PDH_CYC);
  localparam logic [CW-1:0] PDL_C = CW'(PDL_CYC);

  // One-hot slot states
  typedef enum logic [4:0] {
    SWL_S_IDLE = 5'h01,
    SWL_S_LOW = 5'h02,
    SWL_S_WAITHI = 5'h04,
    SWL_S_PDH = 5'h08,
    SWL_S_PDL = 5'h10
  } swl_sst_t;

  // Two-flop synchroniser for the line; the third stage only feeds the edge detector
  logic sync1_q, sync1_d, sync2_q, sync2_d, prev_q, prev_d;
  always_comb begin
    sync1_d = bus.line_in;
    sync2_d = sync1_q;
    prev_d = sync2_q;
  end

  // Reset to the idle-high level so leaving reset never looks like a falling edge
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
    end
  end

  // High for one cycle at a falling edge of the synchronised line
  logic fall;
  assign fall = prev_q & ~sync2_q;

  // Slot controller state
  swl_sst_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic oe_q, oe_d, sampled_q, sampled_d;
  // Single-cycle decode strobes handed from the slot controller to the user side
  logic ev_start, ev_sample, ev_reset;

  // Next-state logic for slot, reset and presence timing
  always_comb begin
    st_d = st_q;
    // Saturate instead of wrapping: a line stuck low must not fake a short count
    cnt_d = (cnt_q == {CW{1'b1}}) ? cnt_q : cnt_q + CW'(1);
    oe_d = oe_q;
    sampled_d = sampled_q;
    ev_start = 1'b0;
    ev_sample = 1'b0;
    ev_reset = 1'b0;
    unique case (st_q)
      SWL_S_IDLE: begin
        // Wait for the master's slot edge
        cnt_d = '0;
        if (fall) begin
          st_d = SWL_S_LOW;
          sampled_d = 1'b0;
          oe_d = ~i_tx_bit;
          ev_start = 1'b1;
        end
      end
      SWL_S_LOW: begin
        // Read zero: keep pulling until the hold delay ends, well past the valid window
        if (oe_q && cnt_q >= HOLD0_C) begin
          oe_d = 1'b0;
        end
        if (!sampled_q && cnt_q == SAMPLE_C) begin
          sampled_d = 1'b1;
          ev_sample = 1'b1;
        end
        // Slot over once the bit is taken and the line is high again
        if (!oe_q && sync2_q && sampled_q) begin
          st_d = SWL_S_IDLE;
        end
        // A long low with our own driver off is a reset
        if (!oe_q && !sync2_q && cnt_q >= RSTDET_C) begin
          st_d = SWL_S_WAITHI;
        end
      end
      SWL_S_WAITHI: begin
        // Wait for the reset low to end
        cnt_d = '0;
        if (sync2_q) begin
          st_d = SWL_S_PDH;
          ev_reset = 1'b1;
        end
      end
      SWL_S_PDH: begin
        // Presence wait; a new low means the master restarted early
        if (!sync2_q) begin
          st_d = SWL_S_LOW;
          cnt_d = '0;
          sampled_d = 1'b0;
        end else if (cnt_q >= PDH_C) begin
          st_d = SWL_S_PDL;
          oe_d = 1'b1;
          cnt_d = '0;
        end
      end
      SWL_S_PDL: begin
        // Presence pulse
        if (cnt_q >= PDL_C) begin
          st_d = SWL_S_IDLE;
          oe_d = 1'b0;
        end
      end
      default: begin
        st_d = SWL_S_IDLE;
        oe_d = 1'b0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_q <= SWL_S_IDLE;
      cnt_q <= '0;
      oe_q <= 1'b0;
      sampled_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      oe_q <= oe_d;
      sampled_q <= sampled_d;
    end
  end

  // User-side events, kept apart so every user output leaves a flip-flop
  logic rxv_q, rxv_d, rxb_q, rxb_d, tk_q, tk_d, rs_q, rs_d;
  always_comb begin
    rxv_d = ev_sample;
    // The bit holds between samples, so the user may read it late
    rxb_d = ev_sample ? sync2_q : rxb_q;
    tk_d = ev_start;
    rs_d = ev_reset;
  end

  // Event registers
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rxv_q <= 1'b0;
      rxb_q <= 1'b0;
      tk_q <= 1'b0;
      rs_q <= 1'b0;
    end else begin
      rxv_q <= rxv_d;
      rxb_q <= rxb_d;
      tk_q <= tk_d;
      rs_q <= rs_d;
    end
  end

  // Line driver and user outputs come straight from registers
  assign bus.slv_oe = oe_q;
  assign o_rx_valid = rxv_q;
  assign o_rx_bit = rxb_q;
  assign o_tx_taken = tk_q;
  assign o_reset_seen = rs_q;
endmodule

// File: rtl/swl_master.sv
// Master end: generates reset, write and read slots
`timescale 1ns/1ns
`include "swl_cfg.svh"
module swl_master #(
  parameter int CW = `SWL_CW
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Shared line
  swl_if.master bus,
  // User command
  input wire logic i_req,
  input wire swl_pkg::swl_op_t i_op,
  input wire logic i_wbit,
  // User answer
  output logic o_busy,
  output logic o_done,
  output logic o_rbit,
  output logic o_presence
);
  localparam logic [CW-1:0] LOW1_C = CW'(`SWL_CYC(`SWL_US_LOW1_USE));
  localparam logic [CW-1:0] LOW0_C = CW'(`SWL_CYC(`SWL_US_LOW0_USE));
  localparam logic [CW-1:0] LOWR_C = CW'(`SWL_CYC(`SWL_US_LOWR_USE));
  localparam logic [CW-1:0] MSMP_C = CW'(`SWL_CYC(`SWL_US_MSAMPLE));
  localparam logic [CW-1:0] SLOT_C = CW'(`SWL_CYC(`SWL_US_SLOT_USE));
  localparam logic [CW-1:0] REC_C = CW'(`SWL_CYC(`SWL_US_REC_USE));
  localparam logic [CW-1:0] RSTL_C = CW'(`SWL_CYC(`SWL_US_RSTL_USE));
  localparam logic [CW-1:0] RSTH_C = CW'(`SWL_CYC(`SWL_US_RSTH_USE));

  typedef enum logic [3:0] {
    SWL_M_IDLE = 4'h1,
    SWL_M_SLOT = 4'h2,
    SWL_M_REC = 4'h4,
    SWL_M_RSTL = 4'h8
  } swl_mst_t;

  // Two-flop synchroniser for the line
  logic sync1_q, sync2_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= bus.line_in;
      sync2_q <= sync1_q;
    end
  end

  swl_mst_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d, low_q, low_d, end_q, end_d;
  logic rd_q, rd_d, oe_q, oe_d, done_q, done_d, rbit_q, rbit_d, pres_q, pres_d;

  // Next-state logic for slot generation
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + CW'(1);
    low_d = low_q;
    end_d = end_q;
    rd_d = rd_q;
    oe_d = oe_q;
    done_d = 1'b0;
    rbit_d = rbit_q;
    pres_d = pres_q;
    unique case (st_q)
      SWL_M_IDLE: begin
        cnt_d = '0;
        if (i_req) begin
          oe_d = 1'b1;
          rd_d = (i_op == swl_pkg::SWL_OP_READ);
          if (i_op == swl_pkg::SWL_OP_RESET) begin
            st_d = SWL_M_RSTL;
            pres_d = 1'b0;
          end else begin
            st_d = SWL_M_SLOT;
            end_d = SLOT_C;
            if (i_op == swl_pkg::SWL_OP_READ) begin
              low_d = LOWR_C;
            end else if (i_wbit) begin
              low_d = LOW1_C;
            end else begin
              low_d = LOW0_C;
            end
          end
        end
      end
      SWL_M_SLOT: begin
        if (cnt_q == low_q) begin
          oe_d = 1'b0;
        end
        if (rd_q && cnt_q == MSMP_C) begin
          rbit_d = sync2_q;
        end
        if (cnt_q == end_q) begin
          st_d = SWL_M_REC;
          cnt_d = '0;
          end_d = REC_C;
        end
      end
      SWL_M_RSTL: begin
        if (cnt_q == RSTL_C) begin
          oe_d = 1'b0;
          st_d = SWL_M_REC;
          cnt_d = '0;
          end_d = RSTH_C;
          rd_d = 1'b1;
        end
      end
      SWL_M_REC: begin
        // After reset, any low from the fourth cycle of the high time on is presence
        if (rd_q && end_q == RSTH_C && !sync2_q && cnt_q > CW'(2)) begin
          pres_d = 1'b1;
        end
        if (cnt_q >= end_q && sync2_q) begin
          st_d = SWL_M_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        st_d = SWL_M_IDLE;
        oe_d = 1'b0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_q <= SWL_M_IDLE;
      cnt_q <= '0;
      low_q <= '0;
      end_q <= '0;
      rd_q <= 1'b0;
      oe_q <= 1'b0;
      done_q <= 1'b0;
      rbit_q <= 1'b0;
      pres_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
      end_q <= end_d;
      rd_q <= rd_d;
      oe_q <= oe_d;
      done_q <= done_d;
      rbit_q <= rbit_d;
      pres_q <= pres_d;
    end
  end

  logic busy_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (st_d != SWL_M_IDLE);
    end
  end

  assign bus.mst_oe = oe_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_rbit = rbit_q;
  assign o_presence = pres_q;
endmodule

// File: test/swl_properties.sv
// Line timing checks for both ends of the slot link
`timescale 1ns/1ns
module swl_properties (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Shared line
  input wire logic mst_oe,
  input wire logic slv_oe,
  input wire logic line_in
);
  logic [15:0] mlo_q, mhi_q, slo_q, sf_q;
  logic rs_q, pr_q;
  wire m_rise = mst_oe && mhi_q != 16'h0;
  wire m_fall = !mst_oe && mlo_q != 16'h0;
  // Run lengths; idle counts start high so the first slot after reset is legal
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      mlo_q <= 16'h0;
      mhi_q <= 16'h2000;
      slo_q <= 16'h0;
      sf_q <= 16'h2000;
      rs_q <= 1'b0;
      pr_q <= 1'b0;
    end else begin
      mlo_q <= mst_oe ? mlo_q + 16'h1 : 16'h0;
      mhi_q <= mst_oe ? 16'h0 : mhi_q + 16'h1;
      slo_q <= slv_oe ? slo_q + 16'h1 : 16'h0;
      sf_q <= m_rise ? 16'h1 : sf_q + 16'h1;
      if (m_fall) rs_q <= mlo_q >= 16'h12c0;
      // A slave pull that starts while the master is idle is a presence pulse
      if (slv_oe && slo_q == 16'h0) pr_q <= !mst_oe;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  property p_rd_start; $rose(slv_oe) && mst_oe |-> mlo_q <= 16'ha; endproperty
  a_rd_start: assert property (p_rd_start) else $error("slave answer late");
  property p_rd_valid; $fell(slv_oe) && !pr_q |-> slo_q >= 16'h93; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read zero too short");
  property p_rd_rel; $fell(slv_oe) && !pr_q |-> slo_q <= 16'h258; endproperty
  a_rd_rel: assert property (p_rd_rel) else $error("read zero too long");
  property p_pres_wait; $rose(slv_oe) && !mst_oe |-> mhi_q inside {[16'h96:16'h258]}; endproperty
  a_pres_wait: assert property (p_pres_wait) else $error("presence wait bad");
  property p_pres_len; $fell(slv_oe) && pr_q |-> slo_q inside {[16'h258:16'h960]}; endproperty
  a_pres_len: assert property (p_pres_len) else $error("presence length bad");
  property p_mlow;
    m_fall |-> mlo_q inside {[16'ha:16'h95], [16'h258:16'h4af], [16'h12c0:16'h2580]};
  endproperty
  a_mlow: assert property (p_mlow) else $error("master low time bad");
  property p_rec; m_rise |-> mhi_q >= (rs_q ? 16'h12c0 : 16'ha); endproperty
  a_rec: assert property (p_rec) else $error("recovery too short");
  property p_slot; m_rise |-> sf_q >= 16'h258; endproperty
  a_slot: assert property (p_slot) else $error("slot too short");
  c_read0: cover property (slv_oe && mst_oe);
  c_pres: cover property (slv_oe && !mst_oe && !line_in);
  c_reset: cover property (m_fall && mlo_q >= 16'h12c0);
endmodule

// File: test/tb_single_wire_slave_time_slots.sv
// Bench joining master and slave over one shared line
`timescale 1ns/1ns
module tb_single_wire_slave_time_slots;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_req = 1'b0;
  swl_pkg::swl_op_t i_op = swl_pkg::SWL_OP_RESET;
  logic i_wbit = 1'b0;
  logic i_tx_bit = 1'b1;
  logic o_busy, o_done, o_rbit, o_presence, o_rx_valid, o_rx_bit, o_tx_taken, o_reset_seen;
  logic rx_last = 1'b0;
  logic [3:0] pat = 4'h9;
  int err_total = 0;
  int check_count = 0;
  int rst_cnt = 0;
  int rx_cnt = 0;
  int tk_cnt = 0;
  int cyc = 0;
  swl_if bus_if();
  swl_master swl_master_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .bus(bus_if.master), .i_req(i_req),
    .i_op(i_op), .i_wbit(i_wbit), .o_busy(o_busy), .o_done(o_done), .o_rbit(o_rbit), .o_presence(o_presence));
  swl_slave swl_slave_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .bus(bus_if.slave), .i_tx_bit(i_tx_bit),
    .o_rx_valid(o_rx_valid), .o_rx_bit(o_rx_bit), .o_tx_taken(o_tx_taken), .o_reset_seen(o_reset_seen));
  swl_properties swl_properties_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .mst_oe(bus_if.mst_oe),
    .slv_oe(bus_if.slv_oe), .line_in(bus_if.line_in));
  // Clock at 10 MHz
  initial begin
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // Slave event capture; the cycle ceiling is about twice the planned run
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (o_rx_valid === 1'b1) rx_last <= o_rx_bit;
    if (o_reset_seen === 1'b1) rst_cnt <= rst_cnt + 1;
    if (o_rx_valid === 1'b1) rx_cnt <= rx_cnt + 1;
    if (o_tx_taken === 1'b1) tk_cnt <= tk_cnt + 1;
    if (cyc == 60000) begin
      err_total = err_total + 1;
      end_of_test();
    end
  end
  task automatic chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One command: hold the request until busy is seen, then wait for done
  task automatic run(input swl_pkg::swl_op_t op, input logic wb, input logic tb);
    @(posedge i_sys_clk);
    i_req <= 1'b1;
    i_op <= op;
    i_wbit <= wb;
    i_tx_bit <= tb;
    do @(posedge i_sys_clk); while (o_busy !== 1'b1);
    i_req <= 1'b0;
    do @(posedge i_sys_clk); while (o_done !== 1'b1);
    $display("test op %h done", op);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Reset, back-to-back writes and reads of 1,0,0,1, then a second reset
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    run(swl_pkg::SWL_OP_RESET, 1'b0, 1'b1);
    chk(o_presence, 1'b1);
    chk(rst_cnt > 0, 1'b1);
    chk(tk_cnt == 1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      run(swl_pkg::SWL_OP_WRITE, pat[i], 1'b1);
      chk(rx_last, pat[i]);
      chk(rx_cnt == i + 2, 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      run(swl_pkg::SWL_OP_READ, 1'b1, pat[i]);
      chk(o_rbit, pat[i]);
    end
    run(swl_pkg::SWL_OP_RESET, 1'b0, 1'b1);
    chk(o_presence, 1'b1);
    chk(rst_cnt > 1, 1'b1);
    chk(tk_cnt == 10, 1'b1);
    chk(rx_cnt == 10, 1'b1);
    end_of_test();
  end
endmodule
